/* design/fpa_arbiter.sv */
`timescale 1ns/1ps
`include "fpa_defs.svh"
module fpa_arbiter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] portEnable,
    input wire logic [3:0] req,
    input wire logic ready,
    input wire logic drop,
    output logic [3:0] grant,
    output logic [3:0] blocked
);
    logic [3:0] grant_reg;
    logic [3:0] grant_next;
    logic [3:0] cand;

    assign blocked[0] = 1'b0;
    for (genvar i = 1; i < `FPA_PORTS; i++) begin : g_block
        assign blocked[i] = |portEnable[i-1:0];
    end
    assign cand = req & ~blocked;

    always_comb begin
        grant_next = 4'h0;
        if ((|(grant_reg & cand)) && !drop) begin
            grant_next = grant_reg;
        end else if (ready && !(|grant_reg)) begin
            // Scan from lowest rank so the highest rank wins
            for (int i = `FPA_PORTS - 1; i >= 0; i--) begin
                if (cand[i]) begin
                    grant_next = 4'(4'h1 << i);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_reg <= 4'h0;
        end else begin
            grant_reg <= grant_next;
        end
    end
    assign grant = grant_reg;
endmodule

/* design/fpa_defs.svh */
`ifndef FPA_DEFS_SVH
`define FPA_DEFS_SVH
// Behaviour
// - Rank: test port, serial, two-wire, fabric bus.
// - Enabled higher port blocks lower port operations.
// - Serial host asserts dedicated flash select.
// - General serial select gets no flash access.
// - Only two-wire suffix 00 reaches flash.
// - Fabric bus reads/writes user and configuration sectors.
// - Interrupt reports read data and arbitration errors.
// - Command 74 suspends power, reset, serial, two-wire.
// - Commands 26 then FF restore suspended functions.
// - Three sectors: user, configuration, feature row.
// - User pages hold 128 bits each.
// - Preload fills highest user pages.
// - Pages below preload read as zero.
// - Byte 15 and bit 127 most significant.
// - Loader supplies ascending 128-bit rows, bounded count.
// - Shared option places RAM data from page 0.
// - Overflow option makes user sector unavailable.
// - Other options leave user sector free.
// - Power-up or refresh loads block RAM data.
// - Host saves RAM pages before user erase.
// - Write covers whole page, sets bits.
// - Erase covers whole sector, clears bits.

`define FPA_PORTS 4
`define FPA_PORT_JTAG 0
`define FPA_PORT_SPI 1
`define FPA_PORT_I2C 2
`define FPA_PORT_WB 3
`define FPA_PAGE_W 128
`define FPA_PAGE_AW 10
`define FPA_UFM_PAGES 640
`define FPA_CFG_PAGES 64
`define FPA_PRELOAD 512
`define FPA_UFM_LAST (10'(`FPA_UFM_PAGES - 1))
`define FPA_CFG_LAST (10'(`FPA_CFG_PAGES - 1))
`define FPA_PRELOAD_BASE (10'(`FPA_UFM_PAGES - `FPA_PRELOAD))
`define FPA_FEATURE_ROW 128'h0
`define FPA_SEC_UFM 2'h0
`define FPA_SEC_CFG 2'h1
`define FPA_SEC_FEAT 2'h2
`define FPA_OP_READ 8'h01
`define FPA_OP_WRITE 8'h02
`define FPA_OP_ERASE 8'h03
`define FPA_OP_REFRESH 8'h04
`define FPA_OP_EN_CFG 8'h74
`define FPA_OP_DIS_CFG 8'h26
`define FPA_OP_BYPASS 8'hff
`define FPA_I2C_FLASH 2'h0
`define FPA_OPT_SHARED 2'h0
`define FPA_OPT_CFG 2'h1
`define FPA_OPT_OVERFLOW 2'h2
`define FPA_OPT_EXTERNAL 2'h3
`define FPA_EBR_CNT 7:0
`define FPA_IRQ_ARB 0
`define FPA_IRQ_RD 1
`define FPA_REG_CTRL 4'h0
`define FPA_REG_PAGE 4'h1
`define FPA_REG_WDATA 4'h2
`define FPA_REG_WDATA_LAST 4'h5
`define FPA_REG_RDATA 4'h6
`define FPA_REG_RDATA_LAST 4'h9
`define FPA_REG_STATUS 4'ha
`define FPA_REG_CFG 4'hb
`define FPA_CTRL_GO 31
`define FPA_CTRL_SEC 17:16
`define FPA_CTRL_OP 15:8
`define FPA_CTRL_PORT 1:0
`define FPA_CFG_EN 3:0
`define FPA_CFG_FSEL 4
`define FPA_CFG_USEL 5
`define FPA_CFG_SUF 7:6
`define FPA_CFG_MASK 9:8
`define FPA_ST_BUSY 0
`define FPA_ST_ERR 1
`define FPA_ST_IRQ 2
`endif

/* design/fpa_device.sv */
// Design decisions made here: the preload row pattern and the block RAM page count held in page 0.
`timescale 1ns/1ps
`include "fpa_defs.svh"
module fpa_device (
    fpa_link_if.device link,
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] storageOption,
    output logic powerCtrlSuspend,
    output logic globalSetResetSuspend,
    output logic userSpiSuspend,
    output logic userI2cSuspend,
    output logic ebrLoadValid,
    output logic [7:0] ebrLoadBlock,
    output logic [`FPA_PAGE_W-1:0] ebrLoadData,
    output logic initBusy
);
    function automatic logic [1:0] portIndex(input logic [3:0] oneHot);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 0; i < `FPA_PORTS; i++) begin
            if (oneHot[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // Row r of the preload image lands on page base + r, byte 15 on top
    function automatic fpa_pkg::fpa_page_type preloadRow(
        input logic [9:0] pageNo
    );
        logic [9:0] row;
        row = 10'(pageNo - `FPA_PRELOAD_BASE);
        return {16{row[7:0]}};
    endfunction

    fpa_pkg::fpa_dev_state_type state_reg;
    logic [9:0] idx_reg;
    logic [7:0] ebrCnt_reg;
    logic [1:0] eraseSec_reg;
    logic [1:0] erasePort_reg;
    logic suspend_reg;
    logic disPend_reg;
    logic arbErr_reg;
    logic rdReady_reg;
    logic [3:0] done_reg;
    logic [3:0] err_reg;
    fpa_pkg::fpa_page_type rdata_reg;
    logic [3:0] doneNext;
    logic [3:0] errNext;
    logic [3:0] grant;
    logic [3:0] blocked;
    logic [3:0] eligible;
    logic [3:0] refuse;

    // Three sectors: user, configuration and the fixed feature row
    fpa_pkg::fpa_page_type ufmMem [0:`FPA_UFM_PAGES-1];
    fpa_pkg::fpa_page_type cfgMem [0:`FPA_CFG_PAGES-1];

    logic [1:0] gi;
    logic act;
    logic [7:0] opc;
    logic [1:0] sec;
    logic [9:0] pg;
    fpa_pkg::fpa_page_type wd;
    fpa_pkg::fpa_page_type rdSel;
    logic flashOp;
    logic secOk;
    logic pageOk;
    logic opOk;
    logic eraseEnd;
    logic shared;

    assign shared = storageOption == `FPA_OPT_SHARED;

    always_comb begin
        gi = portIndex(grant);
        opc = link.opCode[gi];
        sec = link.sector[gi];
        pg = link.page[gi];
        wd = link.wdata[gi];
        act = state_reg == fpa_pkg::ST_IDLE && grant[gi] && link.req[gi]
            && !done_reg[gi] && !blocked[gi];
        flashOp = opc == `FPA_OP_READ || opc == `FPA_OP_WRITE
            || opc == `FPA_OP_ERASE;
        case (sec)
            `FPA_SEC_UFM: begin
                // Overflowed configuration owns the whole user sector
                secOk = storageOption != `FPA_OPT_OVERFLOW;
                pageOk = pg <= `FPA_UFM_LAST;
            end
            `FPA_SEC_CFG: begin
                secOk = 1'b1;
                pageOk = pg <= `FPA_CFG_LAST;
            end
            `FPA_SEC_FEAT: begin
                // Feature row holds port settings: read only, not erasable
                secOk = opc == `FPA_OP_READ;
                pageOk = pg == 10'h0;
            end
            default: begin
                secOk = 1'b0;
                pageOk = 1'b0;
            end
        endcase
        opOk = !flashOp || (suspend_reg && secOk && pageOk);
        case (sec)
            `FPA_SEC_UFM: rdSel = ufmMem[pg];
            `FPA_SEC_CFG: rdSel = cfgMem[pg[5:0]];
            default: rdSel = `FPA_FEATURE_ROW;
        endcase
        eraseEnd = state_reg == fpa_pkg::ST_ERASE
            && idx_reg == ((eraseSec_reg == `FPA_SEC_UFM) ?
                `FPA_UFM_LAST : `FPA_CFG_LAST);
    end

    for (genvar i = 0; i < `FPA_PORTS; i++) begin : g_port
        logic ownErase;
        logic ownAct;
        if (i == `FPA_PORT_SPI) begin : g_spi
            // The general user select never reaches the flash
            assign eligible[i] = !link.flashPortSelect_n;
        end else if (i == `FPA_PORT_I2C) begin : g_i2c
            assign eligible[i] = link.i2cSuffix == `FPA_I2C_FLASH;
        end else begin : g_any
            assign eligible[i] = 1'b1;
        end
        assign ownErase = state_reg == fpa_pkg::ST_ERASE
            && erasePort_reg == 2'(i);
        assign ownAct = act && gi == 2'(i);
        assign refuse[i] = link.req[i] && !done_reg[i] && !ownErase
            && (blocked[i] || !eligible[i]);
        assign doneNext[i] = refuse[i]
            || (ownAct && !(opOk && opc == `FPA_OP_ERASE))
            || (eraseEnd && ownErase);
        assign errNext[i] = refuse[i] || (ownAct && !opOk);
    end

    fpa_arbiter u_arbiter (
        .clk(clk),
        .rst_n(rst_n),
        .portEnable(link.portEnable),
        .req(link.req & eligible & ~done_reg),
        .ready(state_reg == fpa_pkg::ST_IDLE),
        .drop(|(doneNext & grant)),
        .grant(grant),
        .blocked(blocked)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= fpa_pkg::ST_INIT;
            idx_reg <= 10'h0;
            ebrCnt_reg <= 8'h0;
            eraseSec_reg <= `FPA_SEC_UFM;
            erasePort_reg <= 2'h0;
        end else begin
            case (state_reg)
                fpa_pkg::ST_INIT: begin
                    if (idx_reg == `FPA_UFM_LAST) begin
                        idx_reg <= 10'h0;
                        state_reg <= fpa_pkg::ST_LOAD;
                    end else begin
                        idx_reg <= 10'(idx_reg + 10'h1);
                    end
                end
                fpa_pkg::ST_LOAD: begin
                    if (!shared) begin
                        state_reg <= fpa_pkg::ST_IDLE;
                    end else if (idx_reg == 10'h0) begin
                        // Page 0 tells how many block RAM pages follow
                        ebrCnt_reg <= ufmMem[0][`FPA_EBR_CNT];
                        idx_reg <= 10'h1;
                    end else if (idx_reg > {2'h0, ebrCnt_reg}) begin
                        state_reg <= fpa_pkg::ST_IDLE;
                    end else begin
                        idx_reg <= 10'(idx_reg + 10'h1);
                    end
                end
                fpa_pkg::ST_IDLE: begin
                    if (act && opOk && opc == `FPA_OP_ERASE) begin
                        state_reg <= fpa_pkg::ST_ERASE;
                        idx_reg <= 10'h0;
                        eraseSec_reg <= sec;
                        erasePort_reg <= gi;
                    end else if (act && opc == `FPA_OP_REFRESH) begin
                        state_reg <= fpa_pkg::ST_LOAD;
                        idx_reg <= 10'h0;
                    end
                end
                fpa_pkg::ST_ERASE: begin
                    // Erase runs to the end even if preempted meanwhile
                    if (eraseEnd) begin
                        state_reg <= fpa_pkg::ST_IDLE;
                    end else begin
                        idx_reg <= 10'(idx_reg + 10'h1);
                    end
                end
                default: begin
                    state_reg <= fpa_pkg::ST_INIT;
                    idx_reg <= 10'h0;
                end
            endcase
        end
    end

    // Array has no reset: it is filled by the init walk instead
    always_ff @(posedge clk) begin
        if (state_reg == fpa_pkg::ST_INIT) begin
            if (idx_reg >= `FPA_PRELOAD_BASE) begin
                ufmMem[idx_reg] <= preloadRow(idx_reg);
            end else begin
                ufmMem[idx_reg] <= '0;
            end
            if (idx_reg <= `FPA_CFG_LAST) begin
                cfgMem[idx_reg[5:0]] <= '0;
            end
        end else if (state_reg == fpa_pkg::ST_ERASE) begin
            if (eraseSec_reg == `FPA_SEC_UFM) begin
                ufmMem[idx_reg] <= '0;
            end else begin
                cfgMem[idx_reg[5:0]] <= '0;
            end
        end else if (act && opOk && opc == `FPA_OP_WRITE) begin
            // Programming can only raise bits; zeros need an erase
            if (sec == `FPA_SEC_UFM) begin
                ufmMem[pg] <= ufmMem[pg] | wd;
            end else begin
                cfgMem[pg[5:0]] <= cfgMem[pg[5:0]] | wd;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ebrLoadValid <= 1'b0;
            ebrLoadBlock <= 8'h0;
            ebrLoadData <= '0;
        end else begin
            ebrLoadValid <= state_reg == fpa_pkg::ST_LOAD && shared
                && idx_reg != 10'h0 && idx_reg <= {2'h0, ebrCnt_reg};
            ebrLoadBlock <= 8'(idx_reg - 10'h1);
            ebrLoadData <= ufmMem[idx_reg];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            suspend_reg <= 1'b0;
            disPend_reg <= 1'b0;
        end else if (act) begin
            case (opc)
                `FPA_OP_EN_CFG: begin
                    suspend_reg <= 1'b1;
                    disPend_reg <= 1'b0;
                end
                `FPA_OP_DIS_CFG: begin
                    disPend_reg <= suspend_reg;
                end
                `FPA_OP_BYPASS: begin
                    if (disPend_reg) begin
                        suspend_reg <= 1'b0;
                    end
                    disPend_reg <= 1'b0;
                end
                default: begin
                    // Anything between the two commands breaks the pair
                    disPend_reg <= 1'b0;
                end
            endcase
        end
    end
    assign powerCtrlSuspend = suspend_reg;
    assign globalSetResetSuspend = suspend_reg;
    assign userSpiSuspend = suspend_reg;
    assign userI2cSuspend = suspend_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 4'h0;
            err_reg <= 4'h0;
            rdata_reg <= '0;
        end else begin
            done_reg <= doneNext;
            err_reg <= errNext;
            if (act && opOk && opc == `FPA_OP_READ) begin
                rdata_reg <= rdSel;
            end
        end
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arbErr_reg <= 1'b0;
            rdReady_reg <= 1'b0;
        end else begin
            arbErr_reg <= (|(refuse & blocked))
                || (arbErr_reg && !link.irqClear);
            rdReady_reg <= (act && opOk && opc == `FPA_OP_READ
                && gi == 2'(`FPA_PORT_WB))
                || (rdReady_reg && !link.irqClear);
        end
    end

    assign link.irq = (arbErr_reg && link.irqMask[`FPA_IRQ_ARB])
        || (rdReady_reg && link.irqMask[`FPA_IRQ_RD]);
    assign link.done = done_reg;
    assign link.err = err_reg;
    assign link.rdata = rdata_reg;
    assign initBusy = state_reg == fpa_pkg::ST_INIT
        || state_reg == fpa_pkg::ST_LOAD;
endmodule

/* design/fpa_host.sv */
`timescale 1ns/1ps
`include "fpa_defs.svh"
module fpa_host (
    fpa_link_if.host link,
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    logic [1:0] port_reg;
    logic [7:0] op_reg;
    logic [1:0] sec_reg;
    logic [9:0] page_reg;
    logic [3:0][31:0] wdata_reg;
    fpa_pkg::fpa_page_type rdata_reg;
    logic busy_reg;
    logic err_reg;
    logic [3:0] enable_reg;
    logic flashSel_n_reg;
    logic userSel_n_reg;
    logic [1:0] suffix_reg;
    logic [1:0] mask_reg;
    logic irqClear_reg;
    logic rdPend_reg;
    logic [31:0] readMux;
    logic wrTake;
    logic doneHere;

    // Reads take one wait cycle so read data come from a flip-flop
    assign waitrequest = (read && !rdPend_reg) || (write && busy_reg
        && address == `FPA_REG_CTRL && writedata[`FPA_CTRL_GO]);
    assign wrTake = write && !waitrequest;
    assign doneHere = busy_reg && link.done[port_reg];

    always_comb begin
        readMux = 32'h0;
        if (address == `FPA_REG_CTRL) begin
            readMux[`FPA_CTRL_SEC] = sec_reg;
            readMux[`FPA_CTRL_OP] = op_reg;
            readMux[`FPA_CTRL_PORT] = port_reg;
        end else if (address == `FPA_REG_PAGE) begin
            readMux[9:0] = page_reg;
        end else if (address >= `FPA_REG_WDATA
            && address <= `FPA_REG_WDATA_LAST) begin
            readMux = wdata_reg[2'(address - `FPA_REG_WDATA)];
        end else if (address >= `FPA_REG_RDATA
            && address <= `FPA_REG_RDATA_LAST) begin
            readMux = rdata_reg[32 * 2'(address - `FPA_REG_RDATA) +: 32];
        end else if (address == `FPA_REG_STATUS) begin
            readMux[`FPA_ST_BUSY] = busy_reg;
            readMux[`FPA_ST_ERR] = err_reg;
            readMux[`FPA_ST_IRQ] = link.irq;
        end else if (address == `FPA_REG_CFG) begin
            readMux[`FPA_CFG_EN] = enable_reg;
            readMux[`FPA_CFG_FSEL] = flashSel_n_reg;
            readMux[`FPA_CFG_USEL] = userSel_n_reg;
            readMux[`FPA_CFG_SUF] = suffix_reg;
            readMux[`FPA_CFG_MASK] = mask_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdPend_reg <= 1'b0;
            readdata <= 32'h0;
        end else begin
            rdPend_reg <= read && !rdPend_reg;
            if (read && !rdPend_reg) begin
                readdata <= readMux;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_reg <= 2'h0;
            op_reg <= 8'h0;
            sec_reg <= `FPA_SEC_UFM;
            page_reg <= 10'h0;
            wdata_reg <= '0;
            enable_reg <= 4'h0;
            flashSel_n_reg <= 1'b1;
            userSel_n_reg <= 1'b1;
            suffix_reg <= `FPA_I2C_FLASH;
            mask_reg <= 2'h0;
            irqClear_reg <= 1'b0;
        end else begin
            irqClear_reg <= wrTake && address == `FPA_REG_STATUS
                && writedata[`FPA_ST_IRQ];
            if (wrTake && address == `FPA_REG_CTRL && !busy_reg) begin
                port_reg <= writedata[`FPA_CTRL_PORT];
                op_reg <= writedata[`FPA_CTRL_OP];
                sec_reg <= writedata[`FPA_CTRL_SEC];
            end
            if (wrTake && address == `FPA_REG_PAGE) begin
                page_reg <= writedata[9:0];
            end
            if (wrTake && address >= `FPA_REG_WDATA
                && address <= `FPA_REG_WDATA_LAST) begin
                wdata_reg[2'(address - `FPA_REG_WDATA)] <= writedata;
            end
            if (wrTake && address == `FPA_REG_CFG) begin
                enable_reg <= writedata[`FPA_CFG_EN];
                flashSel_n_reg <= writedata[`FPA_CFG_FSEL];
                userSel_n_reg <= writedata[`FPA_CFG_USEL];
                suffix_reg <= writedata[`FPA_CFG_SUF];
                mask_reg <= writedata[`FPA_CFG_MASK];
            end
        end
    end

    // One request in flight; it is dropped at the edge that sees done
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= '0;
        end else if (doneHere) begin
            busy_reg <= 1'b0;
            err_reg <= link.err[port_reg];
            rdata_reg <= link.rdata;
        end else if (wrTake && address == `FPA_REG_CTRL
            && writedata[`FPA_CTRL_GO]) begin
            busy_reg <= 1'b1;
        end
    end

    assign link.req = busy_reg ? 4'(4'h1 << port_reg) : 4'h0;
    for (genvar i = 0; i < `FPA_PORTS; i++) begin : g_lane
        assign link.opCode[i] = op_reg;
        assign link.sector[i] = sec_reg;
        assign link.page[i] = page_reg;
        assign link.wdata[i] = wdata_reg;
    end
    assign link.portEnable = enable_reg;
    assign link.flashPortSelect_n = flashSel_n_reg;
    assign link.userSelect_n = userSel_n_reg;
    assign link.i2cSuffix = suffix_reg;
    assign link.irqMask = mask_reg;
    assign link.irqClear = irqClear_reg;
endmodule

/* design/fpa_link_if.sv */
`timescale 1ns/1ps
interface fpa_link_if;
    logic [3:0] portEnable;
    logic [3:0] req;
    logic [3:0][7:0] opCode;
    logic [3:0][1:0] sector;
    logic [3:0][9:0] page;
    fpa_pkg::fpa_page_type [3:0] wdata;
    logic flashPortSelect_n;
    logic userSelect_n;
    logic [1:0] i2cSuffix;
    logic [1:0] irqMask;
    logic irqClear;
    logic [3:0] done;
    logic [3:0] err;
    fpa_pkg::fpa_page_type rdata;
    logic irq;
    modport device (
        input portEnable, req, opCode, sector, page, wdata,
        input flashPortSelect_n, userSelect_n, i2cSuffix, irqMask, irqClear,
        output done, err, rdata, irq
    );
    modport host (
        output portEnable, req, opCode, sector, page, wdata,
        output flashPortSelect_n, userSelect_n, i2cSuffix, irqMask, irqClear,
        input done, err, rdata, irq
    );
endinterface

/* design/fpa_pkg.sv */
package fpa_pkg;
    typedef logic [127:0] fpa_page_type;
    typedef enum logic [3:0] {
        ST_INIT = 4'h1,
        ST_LOAD = 4'h2,
        ST_IDLE = 4'h4,
        ST_ERASE = 4'h8
    } fpa_dev_state_type;
endpackage

/* tb/flash_port_arbiter_ufm_map_tb.sv */
`timescale 1ns/1ps
module flash_port_arbiter_ufm_map_tb;
    typedef struct packed {
        logic [9:0] cfg;
        logic [1:0] port;
        logic [7:0] op;
        logic [1:0] sec;
        logic [9:0] pg;
        logic er;
        logic [1:0] ex;
    } fpa_row_type;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] storageOption = 2'h1;
    wire [3:0] susp;
    logic initBusy;
    logic [31:0] q;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    fpa_row_type rows [17];
    fpa_link_if lnk ();
    fpa_host fpa_host_i (.link(lnk.host), .clk, .rst_n, .address, .read,
        .write, .writedata, .readdata, .waitrequest);
    fpa_device fpa_device_i (.link(lnk.device), .clk, .rst_n,
        .storageOption, .powerCtrlSuspend(susp[0]),
        .globalSetResetSuspend(susp[1]), .userSpiSuspend(susp[2]),
        .userI2cSuspend(susp[3]), .ebrLoadValid(), .ebrLoadBlock(),
        .ebrLoadData(), .initBusy);
    fpa_link_sva u_sva (.clk, .rst_n, .portEnable(lnk.portEnable),
        .req(lnk.req), .flashPortSelect_n(lnk.flashPortSelect_n),
        .i2cSuffix(lnk.i2cSuffix), .irqMask(lnk.irqMask),
        .done(lnk.done), .err(lnk.err), .irq(lnk.irq));
    always #25 clk = ~clk;
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Erase and init walks are well under a thousand cycles each
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic av(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        logic wt;
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        wt = 1'b1;
        while (wt) begin
            @(posedge clk);
            wt = waitrequest;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic op(input logic [1:0] p, input logic [7:0] o,
        input logic [1:0] s, input logic [9:0] pg);
        av(1'b1, 4'h1, {22'h0, pg});
        av(1'b1, 4'h0, {1'b1, 13'h0, s, o, 6'h0, p});
        q = 32'h1;
        while (q[0]) av(1'b0, 4'ha, 32'h0);
    endtask
    // Byte n of the test page holds n, so byte 15 lands in bits 127:120
    function automatic logic [31:0] ew(input logic [1:0] ex, input int k);
        case (ex)
            2'h2: ew = {8'(4*k+3), 8'(4*k+2), 8'(4*k+1), 8'(4*k)};
            2'h3: ew = 32'h01010101;
            default: ew = 32'h0;
        endcase
    endfunction
    initial begin
        rows = '{
            '{10'h338, 2'h3, 8'h01, 2'h0, 10'h005, 1'h1, 2'h0},
            '{10'h338, 2'h3, 8'h74, 2'h0, 10'h000, 1'h0, 2'h0},
            '{10'h338, 2'h3, 8'h02, 2'h0, 10'h005, 1'h0, 2'h0},
            '{10'h338, 2'h3, 8'h01, 2'h0, 10'h005, 1'h0, 2'h2},
            '{10'h338, 2'h3, 8'h01, 2'h0, 10'h081, 1'h0, 2'h3},
            '{10'h338, 2'h3, 8'h01, 2'h0, 10'h007, 1'h0, 2'h1},
            '{10'h338, 2'h3, 8'h02, 2'h1, 10'h03f, 1'h0, 2'h0},
            '{10'h338, 2'h3, 8'h01, 2'h1, 10'h03f, 1'h0, 2'h2},
            '{10'h338, 2'h3, 8'h01, 2'h0, 10'h280, 1'h1, 2'h0},
            '{10'h338, 2'h3, 8'h02, 2'h2, 10'h000, 1'h1, 2'h0},
            '{10'h332, 2'h1, 8'h01, 2'h0, 10'h005, 1'h1, 2'h0},
            '{10'h322, 2'h1, 8'h01, 2'h0, 10'h005, 1'h0, 2'h2},
            '{10'h374, 2'h2, 8'h01, 2'h0, 10'h005, 1'h1, 2'h0},
            '{10'h334, 2'h2, 8'h01, 2'h0, 10'h005, 1'h0, 2'h2},
            '{10'h339, 2'h3, 8'h01, 2'h0, 10'h005, 1'h1, 2'h0},
            // Config-only option: no block RAM pages to save first
            '{10'h338, 2'h3, 8'h03, 2'h0, 10'h000, 1'h0, 2'h0},
            '{10'h338, 2'h3, 8'h01, 2'h0, 10'h005, 1'h0, 2'h1}};
        repeat (3) @(posedge clk);
        chk({28'h0, susp}, 32'h0);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({31'h0, initBusy}, 32'h1);
        for (int k = 0; k < 4; k++) av(1'b1, 4'h2 + 4'(k), ew(2'h2, k));
        foreach (rows[i]) begin
            av(1'b1, 4'hb, {22'h0, rows[i].cfg});
            op(rows[i].port, rows[i].op, rows[i].sec, rows[i].pg);
            chk({31'h0, q[1]}, {31'h0, rows[i].er});
            for (int k = 0; k < 4 && rows[i].ex != 2'h0; k++) begin
                av(1'b0, 4'h6 + 4'(k), 32'h0);
                chk(q, ew(rows[i].ex, k));
            end
        end
        av(1'b0, 4'ha, 32'h0);
        chk({31'h0, q[2]}, 32'h1);
        av(1'b1, 4'ha, 32'h4);
        av(1'b0, 4'ha, 32'h0);
        chk({31'h0, q[2]}, 32'h0);
        chk({28'h0, susp}, 32'hf);
        storageOption <= 2'h2;
        op(2'h3, 8'h01, 2'h0, 10'h5);
        chk({31'h0, q[1]}, 32'h1);
        chk({31'h0, initBusy}, 32'h0);
        storageOption <= 2'h1;
        op(2'h3, 8'h26, 2'h0, 10'h0);
        op(2'h3, 8'h01, 2'h0, 10'h0);
        op(2'h3, 8'hff, 2'h0, 10'h0);
        chk({28'h0, susp}, 32'hf);
        op(2'h3, 8'h26, 2'h0, 10'h0);
        op(2'h3, 8'hff, 2'h0, 10'h0);
        chk({28'h0, susp}, 32'h0);
        av(1'b1, 4'hc, 32'hffffffff);
        av(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule

/* tb/fpa_link_sva.sv */
`timescale 1ns/1ps
module fpa_link_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] portEnable,
    input wire logic [3:0] req,
    input wire logic flashPortSelect_n,
    input wire logic [1:0] i2cSuffix,
    input wire logic [1:0] irqMask,
    input wire logic [3:0] done,
    input wire logic [3:0] err,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Deselected serial request is refused on the next cycle
    sequence s_refuse_spi;
        ##1 (done[1] && err[1]);
    endsequence
    a_done_onehot: assert property ($onehot0(done))
        else $error("two ports done");
    a_err_done: assert property ((err & ~done) == 4'h0)
        else $error("err without done");
    a_done_req: assert property ((done & ~req) == 4'h0)
        else $error("done without req");
    a_done_pulse: assert property (done != 4'h0 |=> done == 4'h0)
        else $error("done too long");
    a_spi_desel: assert property ($rose(req[1]) && flashPortSelect_n
        |-> s_refuse_spi)
        else $error("serial select ignored");
    a_i2c_suffix: assert property (done[2] && i2cSuffix != 2'h0
        |-> err[2])
        else $error("suffix accepted");
    a_block_fabric: assert property (done[3] && portEnable[2:0] != 3'h0
        |-> err[3])
        else $error("fabric not blocked");
    a_irq_masked: assert property (irqMask == 2'h0 |-> !irq)
        else $error("irq unmasked");
endmodule
